/* sampling_delay_adjust_test.sv */
// self-checking bench for the sampling delay adjust block
// assumes a 25 MHz clock and the calibration stand-in as far side
`timescale 1ns/1ns
module sampling_delay_adjust_test;
   import sda_pkg::*;
   logic clk = 0, rst = 1, clk_en = 1, wr = 0, rd = 0;
   logic [11:0] addr = 12'h000;
   logic [23:0] wdata = 24'h000000;
   logic [23:0] rdata;
   logic rvalid, cal_en = 0, cal_done, ramp_en = 0, ramp_fast = 0;
   logic adc_cal = 0, link_en = 0, inv, done_o, unsafe;
   logic [16:0] cal_dly;
   logic [7:0] coarse, fine;
   int n_fail = 0, tests_run = 0, n_unsafe = 0, n;
   always #20 clk = ~clk;
   // counted mid-cycle, where the registered pulse has settled
   always @(negedge clk) n_unsafe += (unsafe === 1'b1);
   sda_cal_model cal (.i_clock(clk), .i_reset(rst), .i_enable(cal_en),
      .o_complete(cal_done), .o_delay(cal_dly));
   sda_top dut (.I_CLOCK(clk), .I_RESET(rst), .I_CLK_EN(clk_en),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
      .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
      .I_TIMING_CAL_ENABLE(cal_en), .I_TIMING_CAL_COMPLETE(cal_done),
      .I_CALIBRATED_DELAY(cal_dly), .I_RAMP_ENABLE(ramp_en),
      .I_RAMP_FAST(ramp_fast), .I_ADC_CAL_ENABLE(adc_cal),
      .I_SERIAL_LINK_ENABLE(link_en), .O_SAMPLE_CLOCK_INVERT(inv),
      .O_COARSE_DELAY(coarse), .O_FINE_DELAY(fine),
      .O_TIMING_CAL_COMPLETE(done_o), .O_UNSAFE_WRITE(unsafe));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [23:0] dly();
      return {7'h00, inv, coarse, fine};
   endfunction : dly
   task automatic wait_n(input int k);
      repeat (k) @(negedge clk);
   endtask : wait_n
   task automatic wr_reg(input logic [11:0] a, input logic [23:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [11:0] a, input logic [23:0] exp);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      chk({23'h000000, rvalid}, 24'h000001);
      chk(rdata, exp);
   endtask : rd_chk
   task automatic t_manual;
      rd_chk(SDA_ADDR_TIMING_ADJ, 24'h000000);
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'hff5ac3);
      wait_n(3);
      chk(dly(), 24'h015ac3);
      wr_reg(12'h2b6, 24'h000000);
      clk_en = 1'b0;
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h000000);
      clk_en = 1'b1;
      rd_chk(SDA_ADDR_TIMING_ADJ, 24'h015ac3);
      rd_chk(12'h2b6, 24'h000000);
      $display("test manual done");
   endtask : t_manual
   task automatic t_unsafe;
      n = n_unsafe;
      link_en = 1'b1;
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h015b00);
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h015f00);
      wait_n(3);
      chk(dly(), 24'h015f00);
      chk(24'(n_unsafe - n), 24'h000000);
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h016400);
      link_en = 1'b0;
      adc_cal = 1'b1;
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h006400);
      adc_cal = 1'b0;
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h000000);
      wait_n(3);
      chk(24'(n_unsafe - n), 24'h000002);
      $display("test unsafe done");
   endtask : t_unsafe
   task automatic t_ramp;
      ramp_en = 1'b1;
      link_en = 1'b1;
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h000200);
      for (n = 0; n < 500 && coarse === 8'h00; n++) @(negedge clk);
      chk({16'h0000, coarse}, 24'h000001);
      chk(24'(n >= 380 && n <= 390), 24'h000001);
      for (n = 0; n < 500 && coarse !== 8'h02; n++) @(negedge clk);
      chk({16'h0000, coarse}, 24'h000002);
      ramp_fast = 1'b1;
      wr_reg(SDA_ADDR_TIMING_ADJ, 24'h000b00);
      for (n = 0; n < 500 && coarse === 8'h02; n++) @(negedge clk);
      chk({16'h0000, coarse}, 24'h000006);
      ramp_en = 1'b0;
      link_en = 1'b0;
      wait_n(3);
      chk(dly(), 24'h000b00);
      $display("test ramp done");
   endtask : t_ramp
   task automatic t_cal;
      cal_en = 1'b1;
      wait_n(3);
      chk({23'h000000, done_o}, 24'h000000);
      wait_n(25);
      chk({23'h000000, done_o}, 24'h000001);
      chk(dly(), 24'h01a5c3);
      rd_chk(SDA_ADDR_CAL_STATUS, 24'h03a5c3);
      cal_en = 1'b0;
      wait_n(3);
      chk({23'h000000, done_o}, 24'h000000);
      chk(dly(), 24'h000b00);
      $display("test calibration done");
   endtask : t_cal
   initial begin
      #400000;
      n_fail++;
      end_sim();
   end
   initial begin
      wait_n(8);
      rst = 1'b0;
      t_manual();
      t_unsafe();
      t_ramp();
      t_cal();
      end_sim();
   end
endmodule : sampling_delay_adjust_test

/* sda_cal_model.sv */
// stand-in for the timing calibration engine beside the block
// assumes its enable is a level driven on the block's clock
`timescale 1ns/1ns
module sda_cal_model #(
   parameter int DONE_CYCLES = 20,
   parameter logic [16:0] RESULT = 17'h1a5c3
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_enable,
   output logic o_complete,
   output logic [16:0] o_delay
);
   int count_reg;
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset || !i_enable) begin
         count_reg <= 0;
      end else if (count_reg < DONE_CYCLES) begin
         count_reg <= count_reg + 1;
      end
   end
   assign o_complete = i_enable && (count_reg == DONE_CYCLES);
   // result not settled until done, so it churns every cycle while enabled
   assign o_delay = o_complete ? RESULT : ~RESULT ^ 17'(count_reg);
endmodule : sda_cal_model

/* sda_pkg.sv */
// constants, field layout and carrier type for sampling delay adjust
// assumes one device clock domain and a simple register port
// Summary of operation
// - calibrated 17-bit delay is readable; valid only while completion reads one
// - readback bit 16 shows whether calibration inverted the sampling clock
// - readback bits 15:8 hold calibrated coarse step, bits 7:0 fine step
// - manual bit 16 set inverts the sampling clock, clear leaves it normal
// - with calibration off, bits 15:8 set the coarse aperture delay step
// - with calibration off, bits 7:0 set the fine aperture delay step
// - any fine value is accepted at any time without clock glitch
// - bounded coarse steps come from small writes or the device ramp
// - calibration enabled drives delay itself, manual settings are ignored
// - completion reads one only when calibration is enabled and finished
// - slow ramp moves applied coarse one code per 384 clock cycles
package sda_pkg;
   localparam logic [11:0] SDA_ADDR_TIMING_ADJ = 12'h2b5;
   localparam logic [11:0] SDA_ADDR_CAL_STATUS = 12'h2b2;
   localparam int SDA_ADDR_W = 12;
   localparam int SDA_DATA_W = 24;
   localparam int SDA_INV_BIT = 16;
   localparam int SDA_COARSE_MSB = 15;
   localparam int SDA_COARSE_LSB = 8;
   localparam int SDA_FINE_MSB = 7;
   localparam int SDA_FINE_LSB = 0;
   localparam int SDA_DONE_BIT = 17;
   localparam logic [16:0] SDA_TIMING_ADJ_RESET = 17'h00000;
   localparam int SDA_RAMP_INTERVAL = 384;
   localparam int SDA_RAMP_SLOW_STEP = 1;
   localparam int SDA_RAMP_FAST_STEP = 4;
   localparam int SDA_SAFE_COARSE_DELTA = 4;

   typedef struct packed {
      logic inv;
      logic [7:0] coarse;
      logic [7:0] fine;
   } sda_delay_t;
endpackage : sda_pkg

/* sda_ramp.sv */
// coarse delay ramp: walks the applied code toward the written target
// assumes target and controls come from logic on the same clock
`timescale 1ns/1ns
module sda_ramp
   import sda_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int INTERVAL = SDA_RAMP_INTERVAL
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_clk_en,
   input wire logic [WIDTH-1:0] i_target,
   input wire logic i_ramp_en,
   input wire logic i_ramp_fast,
   output logic [WIDTH-1:0] o_current
);
   localparam int CW = $clog2(INTERVAL);
   localparam logic [CW-1:0] LAST = CW'(INTERVAL - 1);

   logic [WIDTH-1:0] cur_reg, cur_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic [WIDTH-1:0] diff, step;

   always_comb begin
      cur_next = cur_reg;
      cnt_next = cnt_reg;
      diff = (i_target > cur_reg) ? i_target - cur_reg : cur_reg - i_target;
      step = i_ramp_fast ? WIDTH'(SDA_RAMP_FAST_STEP) :
             WIDTH'(SDA_RAMP_SLOW_STEP);
      if (!i_ramp_en) begin
         // without ramp the new code applies at once
         cur_next = i_target;
         cnt_next = '0;
      end else if (cur_reg != i_target) begin
         if (cnt_reg == LAST) begin
            cnt_next = '0;
            if (diff <= step) begin
               cur_next = i_target;
            end else if (i_target > cur_reg) begin
               cur_next = cur_reg + step;
            end else begin
               cur_next = cur_reg - step;
            end
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end else begin
         cnt_next = '0;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         cur_reg <= '0;
         cnt_reg <= '0;
      end else if (i_clk_en) begin
         cur_reg <= cur_next;
         cnt_reg <= cnt_next;
      end
   end

   assign o_current = cur_reg;

   sequence s_slow_busy;
      i_clk_en && i_ramp_en && !i_ramp_fast && (cur_reg != i_target);
   endsequence

   property p_ramp_slow_step;
      @(posedge i_clock) disable iff (i_reset)
      s_slow_busy |=> (cur_reg == $past(cur_reg)) ||
         (cur_reg == $past(cur_reg) + 1'b1) ||
         (cur_reg == $past(cur_reg) - 1'b1);
   endproperty
   a_ramp_slow_step: assert property (p_ramp_slow_step)
      else $error("slow ramp moved more than one code");

   property p_ramp_moves_on_interval;
      @(posedge i_clock) disable iff (i_reset)
      i_clk_en && i_ramp_en && (cnt_reg == LAST) && (cur_reg != i_target)
         |=> cur_reg != $past(cur_reg);
   endproperty
   a_ramp_moves_on_interval: assert property (p_ramp_moves_on_interval)
      else $error("ramp did not step at end of interval");

   property p_ramp_cnt_bound;
      @(posedge i_clock) disable iff (i_reset)
      cnt_reg <= LAST;
   endproperty
   a_ramp_cnt_bound: assert property (p_ramp_cnt_bound)
      else $error("ramp interval counter out of range");
endmodule : sda_ramp

/* sda_top.sv */
// sampling clock aperture delay adjust: register, readback, applied delay
// assumes register port, calibration engine and enables share I_CLOCK
`timescale 1ns/1ns
module sda_top
   import sda_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   input wire logic I_CLK_EN,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [SDA_ADDR_W-1:0] I_REG_ADDR,
   input wire logic [SDA_DATA_W-1:0] I_REG_WDATA,
   output logic [SDA_DATA_W-1:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   input wire logic I_TIMING_CAL_ENABLE,
   input wire logic I_TIMING_CAL_COMPLETE,
   input wire logic [16:0] I_CALIBRATED_DELAY,
   input wire logic I_RAMP_ENABLE,
   input wire logic I_RAMP_FAST,
   input wire logic I_ADC_CAL_ENABLE,
   input wire logic I_SERIAL_LINK_ENABLE,
   output logic O_SAMPLE_CLOCK_INVERT,
   output logic [7:0] O_COARSE_DELAY,
   output logic [7:0] O_FINE_DELAY,
   output logic O_TIMING_CAL_COMPLETE,
   output logic O_UNSAFE_WRITE
);
   sda_delay_t tad_reg, tad_next;
   sda_delay_t applied_reg, applied_next;
   sda_delay_t wr_val, cal_val;
   logic [SDA_DATA_W-1:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic done_reg, done_next;
   logic unsafe_reg, unsafe_next;
   logic [7:0] ramp_coarse;
   logic [7:0] coarse_delta;
   logic tad_wr, busy, cal_done;

   always_comb begin
      wr_val = sda_delay_t'(I_REG_WDATA[SDA_INV_BIT:SDA_FINE_LSB]);
      cal_val = sda_delay_t'(I_CALIBRATED_DELAY);
      tad_wr = I_REG_WR && (I_REG_ADDR == SDA_ADDR_TIMING_ADJ);
      busy = I_ADC_CAL_ENABLE || I_SERIAL_LINK_ENABLE;
      cal_done = I_TIMING_CAL_ENABLE && I_TIMING_CAL_COMPLETE;
      coarse_delta = (wr_val.coarse > tad_reg.coarse) ?
                     wr_val.coarse - tad_reg.coarse :
                     tad_reg.coarse - wr_val.coarse;
      // fine is taken on any write, in any state
      tad_next = tad_wr ? wr_val : tad_reg;
      done_next = cal_done;
      // flag only; the write still lands so software keeps control
      unsafe_next = tad_wr && busy &&
         ((wr_val.inv != tad_reg.inv) ||
          (!I_RAMP_ENABLE &&
           (coarse_delta > 8'(SDA_SAFE_COARSE_DELTA))));
      rvalid_next = I_REG_RD;
      rdata_next = '0;
      if (I_REG_RD) begin
         unique case (I_REG_ADDR)
            SDA_ADDR_TIMING_ADJ: begin
               rdata_next = {7'h00, tad_reg};
            end
            SDA_ADDR_CAL_STATUS: begin
               rdata_next = {6'h00, cal_done, I_CALIBRATED_DELAY};
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
      if (I_TIMING_CAL_ENABLE) begin
         applied_next = cal_val;
      end else begin
         applied_next.inv = tad_reg.inv;
         applied_next.coarse = ramp_coarse;
         applied_next.fine = tad_reg.fine;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RESET) begin
      if (I_RESET) begin
         tad_reg <= sda_delay_t'(SDA_TIMING_ADJ_RESET);
         applied_reg <= sda_delay_t'(SDA_TIMING_ADJ_RESET);
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
         done_reg <= 1'b0;
         unsafe_reg <= 1'b0;
      end else if (I_CLK_EN) begin
         tad_reg <= tad_next;
         applied_reg <= applied_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         done_reg <= done_next;
         unsafe_reg <= unsafe_next;
      end
   end

   sda_ramp #(
      .WIDTH(8),
      .INTERVAL(SDA_RAMP_INTERVAL)
   ) u_ramp (
      .i_clock(I_CLOCK),
      .i_reset(I_RESET),
      .i_clk_en(I_CLK_EN),
      .i_target(tad_reg.coarse),
      .i_ramp_en(I_RAMP_ENABLE),
      .i_ramp_fast(I_RAMP_FAST),
      .o_current(ramp_coarse)
   );

   assign O_REG_RDATA = rdata_reg;
   assign O_REG_RVALID = rvalid_reg;
   assign O_SAMPLE_CLOCK_INVERT = applied_reg.inv;
   assign O_COARSE_DELAY = applied_reg.coarse;
   assign O_FINE_DELAY = applied_reg.fine;
   assign O_TIMING_CAL_COMPLETE = done_reg;
   assign O_UNSAFE_WRITE = unsafe_reg;

   sequence s_status_read;
      I_CLK_EN && I_REG_RD && (I_REG_ADDR == SDA_ADDR_CAL_STATUS);
   endsequence

   sequence s_tad_write_manual;
      (I_CLK_EN && tad_wr) ##1 (I_CLK_EN && !I_TIMING_CAL_ENABLE);
   endsequence

   sequence s_manual_two;
      (I_CLK_EN && !I_RAMP_ENABLE && !I_TIMING_CAL_ENABLE) [*2];
   endsequence

   property p_readback;
      @(posedge I_CLOCK) disable iff (I_RESET)
      s_status_read |=> O_REG_RVALID &&
         (O_REG_RDATA[16:0] == $past(I_CALIBRATED_DELAY));
   endproperty
   a_readback: assert property (p_readback)
      else $error("calibrated delay readback wrong");

   property p_done_flag;
      @(posedge I_CLOCK) disable iff (I_RESET)
      s_status_read |=> (O_REG_RDATA[SDA_DONE_BIT] ==
         $past(I_TIMING_CAL_ENABLE && I_TIMING_CAL_COMPLETE)) &&
         (O_TIMING_CAL_COMPLETE == O_REG_RDATA[SDA_DONE_BIT]);
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("completion flag wrong");

   property p_manual_invert;
      @(posedge I_CLOCK) disable iff (I_RESET)
      s_tad_write_manual |=>
         O_SAMPLE_CLOCK_INVERT == $past(I_REG_WDATA[SDA_INV_BIT], 2);
   endproperty
   a_manual_invert: assert property (p_manual_invert)
      else $error("manual inversion not applied");

   property p_manual_fine;
      @(posedge I_CLOCK) disable iff (I_RESET)
      s_tad_write_manual |=>
         O_FINE_DELAY == $past(I_REG_WDATA[SDA_FINE_MSB:SDA_FINE_LSB], 2);
   endproperty
   a_manual_fine: assert property (p_manual_fine)
      else $error("manual fine delay not applied");

   property p_manual_coarse;
      @(posedge I_CLOCK) disable iff (I_RESET)
      s_manual_two |=> O_COARSE_DELAY == $past(tad_reg.coarse, 2);
   endproperty
   a_manual_coarse: assert property (p_manual_coarse)
      else $error("manual coarse delay not applied");

   property p_cal_override;
      @(posedge I_CLOCK) disable iff (I_RESET)
      I_CLK_EN && I_TIMING_CAL_ENABLE |=>
         {O_SAMPLE_CLOCK_INVERT, O_COARSE_DELAY, O_FINE_DELAY} ==
         $past(I_CALIBRATED_DELAY);
   endproperty
   a_cal_override: assert property (p_cal_override)
      else $error("calibration did not override manual delay");

   property p_unsafe_invert;
      @(posedge I_CLOCK) disable iff (I_RESET)
      I_CLK_EN && tad_wr && busy &&
         (I_REG_WDATA[SDA_INV_BIT] != tad_reg.inv) |=> O_UNSAFE_WRITE;
   endproperty
   a_unsafe_invert: assert property (p_unsafe_invert)
      else $error("inversion change while busy not flagged");

   property p_unsafe_coarse;
      @(posedge I_CLOCK) disable iff (I_RESET)
      I_CLK_EN && tad_wr && busy && !I_RAMP_ENABLE &&
         (coarse_delta > 8'(SDA_SAFE_COARSE_DELTA)) |=> O_UNSAFE_WRITE;
   endproperty
   a_unsafe_coarse: assert property (p_unsafe_coarse)
      else $error("large coarse step while busy not flagged");

   property p_idle_no_flag;
      @(posedge I_CLOCK) disable iff (I_RESET)
      I_CLK_EN && !busy |=> !O_UNSAFE_WRITE;
   endproperty
   a_idle_no_flag: assert property (p_idle_no_flag)
      else $error("unsafe flag raised while idle");

   property p_fine_any_state;
      @(posedge I_CLOCK) disable iff (I_RESET)
      I_CLK_EN && tad_wr |=>
         tad_reg.fine == $past(I_REG_WDATA[SDA_FINE_MSB:SDA_FINE_LSB]);
   endproperty
   a_fine_any_state: assert property (p_fine_any_state)
      else $error("fine delay write not taken");

   // frozen enable must hold every output but the completion flag, ramp included
   property p_clk_en_freeze;
      @(posedge I_CLOCK) disable iff (I_RESET)
      !I_CLK_EN |=> $stable({O_SAMPLE_CLOCK_INVERT, O_COARSE_DELAY,
         O_FINE_DELAY, O_REG_RVALID, O_REG_RDATA, O_UNSAFE_WRITE});
   endproperty
   a_clk_en_freeze: assert property (p_clk_en_freeze)
      else $error("state moved while clock enable low");

   property p_unmapped_read;
      @(posedge I_CLOCK) disable iff (I_RESET)
      I_CLK_EN && I_REG_RD && (I_REG_ADDR != SDA_ADDR_TIMING_ADJ) &&
         (I_REG_ADDR != SDA_ADDR_CAL_STATUS) |=> O_REG_RDATA == '0;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read returned data");
endmodule : sda_top
